// file: logic/readback_addr_decode.sv
// combinational decode of a readback-select payload into register kind and index
`timescale 1ns/1ps
`default_nettype none
module readback_addr_decode (
  input wire logic [15:0] payload_in,
  output readback_select_pkg::sel_kind_e kind_out,
  output logic [5:0] index_out
);
  logic [2:0] reg_type;
  logic [5:0] code;
  assign reg_type = payload_in[readback_select_pkg::TYPE_HI:readback_select_pkg::TYPE_LO];
  // bits 6..0 never reach the decode
  assign code = payload_in[readback_select_pkg::CODE_HI:readback_select_pkg::CODE_LO];
  always_comb begin
    kind_out = readback_select_pkg::SEL_NONE;
    index_out = 6'h00;
    case (reg_type)
      readback_select_pkg::TYPE_IN_A, readback_select_pkg::TYPE_IN_B,
      readback_select_pkg::TYPE_OFFSET_TRIM, readback_select_pkg::TYPE_GAIN_TRIM: begin
        if (code >= readback_select_pkg::CHAN_FIRST && code <= readback_select_pkg::CHAN_LAST) begin
          index_out = code - readback_select_pkg::CHAN_FIRST;
          case (reg_type)
            readback_select_pkg::TYPE_IN_A: kind_out = readback_select_pkg::SEL_INPUT_A;
            readback_select_pkg::TYPE_IN_B: kind_out = readback_select_pkg::SEL_INPUT_B;
            readback_select_pkg::TYPE_OFFSET_TRIM: kind_out = readback_select_pkg::SEL_OFFSET_TRIM;
            default: kind_out = readback_select_pkg::SEL_GAIN_TRIM;
          endcase
        end
      end
      readback_select_pkg::TYPE_SYSTEM: begin
        if (code == readback_select_pkg::CODE_CONTROL) begin
          kind_out = readback_select_pkg::SEL_CONTROL;
        end else if (code >= readback_select_pkg::CODE_OFFSET_DAC_0 &&
                     code <= readback_select_pkg::CODE_OFFSET_DAC_2) begin
          kind_out = readback_select_pkg::SEL_OFFSET_DAC;
          index_out = code - readback_select_pkg::CODE_OFFSET_DAC_0;
        end else if (code >= readback_select_pkg::CODE_AB_SEL_0 &&
                     code <= readback_select_pkg::CODE_AB_SEL_4) begin
          kind_out = readback_select_pkg::SEL_AB_SELECT;
          index_out = code - readback_select_pkg::CODE_AB_SEL_0;
        end
      end
      default: begin
        kind_out = readback_select_pkg::SEL_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: logic/readback_select_decoder.sv
// readback select decoder: latches the selection and arms shift-out for the next valid frame, if that frame is a nop
`timescale 1ns/1ps
`default_nettype none
module readback_select_decoder (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic frame_valid_in,
  input wire logic [23:0] frame_in,
  output logic sel_valid_out,
  output readback_select_pkg::sel_kind_e sel_kind_out,
  output logic [5:0] sel_index_out,
  output logic [15:0] sel_payload_out,
  output logic readback_start_out
);
  logic special_mode;
  logic is_readback;
  logic is_nop;
  readback_select_pkg::sel_kind_e dec_kind;
  logic [5:0] dec_index;
  logic armed_q;

  assign special_mode = frame_in[readback_select_pkg::MODE_HI:readback_select_pkg::MODE_LO]
                        == readback_select_pkg::MODE_SPECIAL;
  assign is_readback = frame_valid_in && special_mode &&
    frame_in[readback_select_pkg::FUNC_HI:readback_select_pkg::FUNC_LO]
    == readback_select_pkg::FUNC_READBACK;
  assign is_nop = frame_valid_in && special_mode &&
    frame_in[readback_select_pkg::FUNC_HI:readback_select_pkg::FUNC_LO]
    == readback_select_pkg::FUNC_NOP;

  readback_addr_decode u_decode (
    .payload_in(frame_in[15:0]),
    .kind_out(dec_kind),
    .index_out(dec_index)
  );

  // latch the payload as the readback target
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sel_payload_out <= readback_select_pkg::PAYLOAD_RESET;
      sel_kind_out <= readback_select_pkg::SEL_NONE;
      sel_index_out <= 6'h00;
      sel_valid_out <= 1'b0;
    end else if (is_readback) begin
      sel_payload_out <= frame_in[15:0];
      sel_kind_out <= dec_kind;
      sel_index_out <= dec_index;
      sel_valid_out <= dec_kind != readback_select_pkg::SEL_NONE;
    end
  end

  // arm after select, shift out only if the next valid frame is a nop
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      armed_q <= 1'b0;
      readback_start_out <= 1'b0;
    end else begin
      readback_start_out <= armed_q && is_nop;
      if (frame_valid_in) begin
        armed_q <= is_readback;
      end
    end
  end

  a_latch_on_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback |=> sel_payload_out == $past(frame_in[15:0]))
    else $error("payload not latched on readback select");
  a_hold_selection: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !is_readback |=> $stable(sel_payload_out) && $stable(sel_kind_out) &&
    $stable(sel_index_out) && $stable(sel_valid_out))
    else $error("selection changed without readback select");
  a_foreign_mode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    frame_valid_in && !special_mode |=> !readback_start_out && $stable(sel_payload_out))
    else $error("non special frame acted as special function");
  a_bits_ignored: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h011 |=> sel_kind_out == readback_select_pkg::SEL_INPUT_A
    && sel_index_out == 6'h09)
    else $error("low payload bits altered selection");
  a_first_channel: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h008 |=> sel_valid_out && sel_index_out == 6'h00)
    else $error("first channel mis-decoded");
  a_chan_range: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sel_kind_out inside {readback_select_pkg::SEL_INPUT_A, readback_select_pkg::SEL_INPUT_B,
    readback_select_pkg::SEL_OFFSET_TRIM, readback_select_pkg::SEL_GAIN_TRIM}
    |-> sel_index_out <= 6'h27)
    else $error("channel index beyond last channel");
  a_last_channel: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h06f |=> sel_kind_out ==
    readback_select_pkg::SEL_INPUT_B && sel_index_out == 6'h27)
    else $error("last channel mis-decoded");
  a_offset_trim: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h088 |=> sel_kind_out ==
    readback_select_pkg::SEL_OFFSET_TRIM && sel_index_out == 6'h00)
    else $error("offset trim register mis-decoded");
  a_gain_trim: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h0c8 |=> sel_kind_out ==
    readback_select_pkg::SEL_GAIN_TRIM && sel_index_out == 6'h00)
    else $error("gain trim register mis-decoded");
  a_ab_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h10a |=> sel_kind_out ==
    readback_select_pkg::SEL_AB_SELECT && sel_index_out == 6'h04)
    else $error("ab select register 4 mis-decoded");
  a_control_sel: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h101 |=> sel_kind_out == readback_select_pkg::SEL_CONTROL)
    else $error("control register mis-decoded");
  a_offset_dac: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h104 |=> sel_kind_out ==
    readback_select_pkg::SEL_OFFSET_DAC && sel_index_out == 6'h02)
    else $error("offset dac register 2 mis-decoded");
  a_undef_code: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback && frame_in[15:7] == 9'h105 |=> !sel_valid_out &&
    sel_kind_out == readback_select_pkg::SEL_NONE)
    else $error("undefined system code selected a register");
  a_shift_start: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback ##1 !frame_valid_in ##1 is_nop |=> readback_start_out)
    else $error("nop after select did not start shift out");
  a_start_pulse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    readback_start_out |=> !readback_start_out)
    else $error("shift out start longer than one cycle");
  a_disarm_other: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    is_readback ##1 !frame_valid_in ##1 (frame_valid_in && !is_nop) ##1 !frame_valid_in
    ##1 is_nop |=> !readback_start_out)
    else $error("nop after cancelled select started shift out");
  a_no_spurious: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    readback_start_out |-> $past(is_nop))
    else $error("shift out started without nop frame");
endmodule
`default_nettype wire

// file: logic/readback_select_pkg.sv
// constants and types for the readback select decoder
// Notes on behaviour
// - mode bits 00 make frame bits 21..16 a function code, low 16 bits payload
// - readback-select code latches the payload as next frame's readback target
// - payload 15..13 picks register type, bits 12..7 pick the channel
// - channel field 001000 is the first channel, 101111 the fortieth
// - type 100 with codes 000110..001010 selects A/B select registers 0..4
// - payload bits 6..0 never change the selection
// - the following no-operation frame shifts the selected register out
`default_nettype none
package readback_select_pkg;
  localparam int FRAME_W = 24;
  localparam int DATA_W = 16;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 22;
  localparam int FUNC_HI = 21;
  localparam int FUNC_LO = 16;
  localparam int TYPE_HI = 15;
  localparam int TYPE_LO = 13;
  localparam int CODE_HI = 12;
  localparam int CODE_LO = 7;
  localparam int CHAN_W = 6;
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [5:0] FUNC_NOP = 6'h00;
  localparam logic [5:0] FUNC_READBACK = 6'h05;
  localparam logic [2:0] TYPE_IN_A = 3'h0;
  localparam logic [2:0] TYPE_IN_B = 3'h1;
  localparam logic [2:0] TYPE_OFFSET_TRIM = 3'h2;
  localparam logic [2:0] TYPE_GAIN_TRIM = 3'h3;
  localparam logic [2:0] TYPE_SYSTEM = 3'h4;
  localparam logic [5:0] CHAN_FIRST = 6'h08;
  localparam logic [5:0] CHAN_LAST = 6'h2f;
  localparam logic [5:0] CODE_CONTROL = 6'h01;
  localparam logic [5:0] CODE_OFFSET_DAC_0 = 6'h02;
  localparam logic [5:0] CODE_OFFSET_DAC_2 = 6'h04;
  localparam logic [5:0] CODE_AB_SEL_0 = 6'h06;
  localparam logic [5:0] CODE_AB_SEL_4 = 6'h0a;
  localparam logic [15:0] PAYLOAD_RESET = 16'h0000;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_INPUT_A, SEL_INPUT_B, SEL_OFFSET_TRIM, SEL_GAIN_TRIM,
    SEL_CONTROL, SEL_OFFSET_DAC, SEL_AB_SELECT
  } sel_kind_e;
endpackage
`default_nettype wire

// file: test/host_frame_source.sv
// host serial port model that hands whole frames to the decoder
`timescale 1ns/1ps
`default_nettype none
module host_frame_source (
  input wire logic clk_in,
  output logic frame_valid_out,
  output logic [23:0] frame_out
);
  initial begin
    frame_valid_out = 1'b0;
    frame_out = 24'h000000;
  end
  task automatic send(input logic [23:0] word);
    @(posedge clk_in);
    frame_valid_out <= 1'b1;
    frame_out <= word;
    @(posedge clk_in);
    frame_valid_out <= 1'b0;
    // released bus shows the inverse, never the stale frame
    frame_out <= ~word;
  endtask
endmodule
`default_nettype wire

// file: test/test_readback_select_decoder.sv
// self-checking bench for the readback select decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_readback_select_decoder;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  wire logic fv;
  wire logic [23:0] fr;
  logic sel_valid_out, readback_start_out;
  readback_select_pkg::sel_kind_e sel_kind_out, k;
  logic [5:0] sel_index_out;
  logic [15:0] sel_payload_out;
  int miscompares = 0;
  int comparisons = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  host_frame_source host (.clk_in(clk_sys_in), .frame_valid_out(fv), .frame_out(fr));
  readback_select_decoder dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .frame_valid_in(fv), .frame_in(fr), .sel_valid_out(sel_valid_out),
    .sel_kind_out(sel_kind_out), .sel_index_out(sel_index_out),
    .sel_payload_out(sel_payload_out), .readback_start_out(readback_start_out));
  task automatic pick(input logic [15:0] p, input readback_select_pkg::sel_kind_e ek,
      input logic [5:0] i);
    host.send({2'h0, readback_select_pkg::FUNC_READBACK, p});
    #1;
    `CHK("sel_kind", ek, sel_kind_out)
    `CHK("sel_index", i, sel_index_out)
    `CHK("sel_valid", ek != readback_select_pkg::SEL_NONE, sel_valid_out)
    `CHK("sel_payload", p, sel_payload_out)
  endtask
  task automatic t_channels();
    for (int t = 0; t < 4; t++) begin
      for (int c = 0; c < 40; c++) begin
        k = readback_select_pkg::sel_kind_e'(4'(t + 1));
        pick({3'(t), 6'(c + 8), 7'(c * 3)}, k, 6'(c));
      end
    end
    $display("test channels done");
  endtask
  task automatic t_system();
    for (int c = 1; c < 11; c++) begin
      k = c == 1 ? readback_select_pkg::SEL_CONTROL : c < 5 ? readback_select_pkg::SEL_OFFSET_DAC
        : c == 5 ? readback_select_pkg::SEL_NONE : readback_select_pkg::SEL_AB_SELECT;
      pick({3'h4, 6'(c), 7'h7f}, k, 6'((c < 2 || c == 5) ? 0 : c < 5 ? c - 2 : c - 6));
    end
    $display("test system registers done");
  endtask
  task automatic t_refuse();
    pick({3'h0, 6'h07, 7'h00}, readback_select_pkg::SEL_NONE, 6'h00);
    pick({3'h1, 6'h30, 7'h55}, readback_select_pkg::SEL_NONE, 6'h00);
    pick({3'h5, 6'h08, 7'h00}, readback_select_pkg::SEL_NONE, 6'h00);
    pick(16'h0400, readback_select_pkg::SEL_INPUT_A, 6'h00);
    host.send({2'h0, 6'h02, 16'h2b80});
    host.send({2'h3, readback_select_pkg::FUNC_READBACK, 16'h2000});
    #1;
    `CHK("held_payload", 16'h0400, sel_payload_out)
    `CHK("held_kind", readback_select_pkg::SEL_INPUT_A, sel_kind_out)
    $display("test refused frames done");
  endtask
  task automatic t_readback();
    pick({3'h3, 6'h2f, 7'h01}, readback_select_pkg::SEL_GAIN_TRIM, 6'h27);
    host.send(24'h000000);
    #1;
    `CHK("start_pulse", 1'b1, readback_start_out)
    @(posedge clk_sys_in);
    #1;
    `CHK("start_end", 1'b0, readback_start_out)
    `CHK("kept_index", 6'h27, sel_index_out)
    host.send(24'h000000);
    #1;
    `CHK("lone_nop", 1'b0, readback_start_out)
    pick(16'h2400, readback_select_pkg::SEL_INPUT_B, 6'h00);
    host.send({2'h1, 22'h000123});
    host.send(24'h000000);
    #1;
    `CHK("cancelled", 1'b0, readback_start_out)
    $display("test readback sequence done");
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
    `CHK("reset_kind", readback_select_pkg::SEL_NONE, sel_kind_out)
    `CHK("reset_start", 1'b0, readback_start_out)
    t_channels();
    t_system();
    t_refuse();
    t_readback();
    close_out();
  end
endmodule
`default_nettype wire
